/* rtl/stc_counter.sv */
// Timestamp counter with full-width and reference-split modes and command register
`timescale 1ns/1ns
module stc_counter
    import stc_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // Register port
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_WDATA_IN,
    output logic [31:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    // Host wall-clock time and date, sampled on capture
    input wire logic [31:0] HOST_TIME_IN,
    input wire logic [31:0] HOST_DATE_IN,
    // Acquisition events, same clock domain
    input wire logic CARD_START_IN,
    input wire logic TRIGGER_IN,
    // External reference pin
    input wire logic REF_CLOCK_IN,
    // Outputs
    output logic [63:0] STAMP_OUT,
    output logic STAMP_VALID_OUT,
    output logic [63:0] COUNT_OUT,
    output logic AWAITING_EDGE_OUT,
    output logic SYNC_TIMEOUT_OUT
);
    logic [31:0] command_q, command_d;
    logic [31:0] timeout_q, timeout_d;
    logic [31:0] start_time_q, start_time_d;
    logic [31:0] start_date_q, start_date_d;
    logic [63:0] count_q, count_d;
    logic [63:0] stamp_q, stamp_d;
    logic stamp_valid_q, stamp_valid_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic ref_meta_q, ref_sync_q, ref_prev_q;
    stc_state_t state_q, state_d;
    logic [16:0] ms_tick_q, ms_tick_d;
    logic [31:0] ms_count_q, ms_count_d;
    logic sync_timeout_q, sync_timeout_d;

    logic enabled, split_mode, ref_edge, cmd_write, clear_cmd, await_cmd;

    // Reference pin crosses two flops before use
    // Edge flop resets low like the idle pin, so leaving reset shows no false edge
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            ref_meta_q <= 1'b0;
            ref_sync_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end
        else
        begin
            ref_meta_q <= REF_CLOCK_IN;
            ref_sync_q <= ref_meta_q;
            ref_prev_q <= ref_sync_q;
        end
    end

    always_comb
    begin
        enabled = (command_q != STC_STAMP_OFF_CODE); // [R3]
        split_mode = command_q[STC_BIT_SPLIT_RISE] | command_q[STC_BIT_SPLIT_FALL];
        // Falling source wins only if rising is not also set
        if (command_q[STC_BIT_SPLIT_RISE])
        begin
            ref_edge = ref_sync_q & ~ref_prev_q; // [R21]
        end
        else if (command_q[STC_BIT_SPLIT_FALL])
        begin
            ref_edge = ~ref_sync_q & ref_prev_q; // [R21]
        end
        else
        begin
            ref_edge = 1'b0;
        end
        cmd_write = REG_WR_IN && (REG_ADDR_IN == STC_ADDR_COMMAND);
        // Command bits act on the write; mode bits persist in the register
        clear_cmd = cmd_write && REG_WDATA_IN[STC_BIT_CLEAR_CMD]; // [R5]
        await_cmd = cmd_write && REG_WDATA_IN[STC_BIT_AWAIT_CMD]; // [R22]
    end

    // Register file
    always_comb
    begin
        command_d = command_q;
        timeout_d = timeout_q;
        if (REG_WR_IN)
        begin
            if (REG_ADDR_IN == STC_ADDR_COMMAND)
            begin
                // A pure command word keeps the programmed mode
                if (REG_WDATA_IN[STC_BIT_CLEAR_CMD] || REG_WDATA_IN[STC_BIT_AWAIT_CMD])
                begin
                    command_d = command_q;
                end
                else
                begin
                    command_d = REG_WDATA_IN; // [R2]
                end
            end
            else if (REG_ADDR_IN == STC_ADDR_TIMEOUT)
            begin
                timeout_d = REG_WDATA_IN; // [R19]
            end
        end
    end

    // Read data holds until the next read, so software may pick it up late
    always_comb
    begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (REG_RD_IN)
        begin
            rvalid_d = 1'b1;
            if (REG_ADDR_IN == STC_ADDR_COMMAND)
            begin
                rdata_d = command_q; // [R2]
            end
            else if (REG_ADDR_IN == STC_ADDR_START_TIME)
            begin
                rdata_d = {8'h00, start_time_q[23:0]}; // [R17]
            end
            else if (REG_ADDR_IN == STC_ADDR_START_DATE)
            begin
                rdata_d = start_date_q; // [R18]
            end
            else if (REG_ADDR_IN == STC_ADDR_TIMEOUT)
            begin
                rdata_d = timeout_q;
            end
            else
            begin
                // Unmapped addresses read as zero
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // Counter
    always_comb
    begin
        count_d = count_q;
        // Clear outranks start and disable, so software can zero a stopped counter
        if (clear_cmd || await_cmd)
        begin
            count_d = 64'h0; // [R5] [R6] [R16] [R22]
        end
        else if (!enabled)
        begin
            count_d = count_q; // [R24]
        end
        else if (command_q[STC_BIT_START_MODE] && CARD_START_IN) // [R4]
        begin
            count_d = 64'h0; // [R9]
        end
        else if (split_mode)
        begin
            if (ref_edge)
            begin
                // Upper edges since clear; lower position in period [R12] [R13] [R14] [R15]
                count_d = {count_q[63:32] + 32'h1, 32'h0}; // [R23]
            end
            else
            begin
                count_d = {count_q[63:32], count_q[31:0] + 32'h1}; // [R14] [R23]
            end
        end
        else
        begin
            // Free-running regardless of start/stop [R7] [R10] [R11]
            count_d = count_q + 64'h1; // [R23]
        end
    end

    // Trigger capture
    always_comb
    begin
        stamp_d = stamp_q;
        stamp_valid_d = 1'b0;
        // Stamp holds its last value until the next enabled trigger
        if (enabled && TRIGGER_IN) // [R24]
        begin
            stamp_d = count_q; // [R8]
            stamp_valid_d = 1'b1;
        end
    end

    // Reference-edge wait and start time/date capture
    always_comb
    begin
        state_d = state_q;
        ms_tick_d = ms_tick_q;
        ms_count_d = ms_count_q;
        sync_timeout_d = sync_timeout_q;
        start_time_d = start_time_q;
        start_date_d = start_date_q;
        case (state_q)
            STC_IDLE:
            begin
                if (await_cmd)
                begin
                    state_d = STC_AWAIT; // [R22]
                    ms_tick_d = 17'h0;
                    ms_count_d = 32'h0;
                    sync_timeout_d = 1'b0;
                end
                else if (clear_cmd)
                begin
                    start_time_d = HOST_TIME_IN;
                    start_date_d = HOST_DATE_IN;
                    sync_timeout_d = 1'b0;
                end
            end
            STC_AWAIT:
            begin
                if (ref_edge)
                begin
                    start_time_d = HOST_TIME_IN; // [R22]
                    start_date_d = HOST_DATE_IN;
                    state_d = STC_IDLE;
                end
                // A zero timeout gives up on the first waiting cycle
                else if (ms_count_q >= timeout_q)
                begin
                    sync_timeout_d = 1'b1; // [R19]
                    state_d = STC_IDLE;
                end
                else if (ms_tick_q == STC_CYCLES_PER_MS - 17'h1)
                begin
                    ms_tick_d = 17'h0;
                    ms_count_d = ms_count_q + 32'h1;
                end
                else
                begin
                    ms_tick_d = ms_tick_q + 17'h1;
                end
            end
            default:
            begin
                state_d = STC_IDLE;
            end
        endcase
    end

    // Programmed registers
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            command_q <= STC_COMMAND_RESET;
            timeout_q <= STC_TIMEOUT_RESET;
        end
        else
        begin
            command_q <= command_d;
            timeout_q <= timeout_d;
        end
    end

    // Read port
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Live counter
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            count_q <= 64'h0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // Captured stamp
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            stamp_q <= 64'h0;
            stamp_valid_q <= 1'b0;
        end
        else
        begin
            stamp_q <= stamp_d;
            stamp_valid_q <= stamp_valid_d;
        end
    end

    // Edge wait and start time/date
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_q <= STC_IDLE;
            ms_tick_q <= 17'h0;
            ms_count_q <= 32'h0;
            sync_timeout_q <= 1'b0;
            start_time_q <= 32'h0;
            start_date_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            ms_tick_q <= ms_tick_d;
            ms_count_q <= ms_count_d;
            sync_timeout_q <= sync_timeout_d;
            start_time_q <= start_time_d;
            start_date_q <= start_date_d;
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign REG_RVALID_OUT = rvalid_q;
    assign STAMP_OUT = stamp_q;
    assign STAMP_VALID_OUT = stamp_valid_q;
    assign COUNT_OUT = count_q;
    assign AWAITING_EDGE_OUT = (state_q == STC_AWAIT);
    assign SYNC_TIMEOUT_OUT = sync_timeout_q;
endmodule : stc_counter

/* shared/stc_pkg.sv */
// Constants and types for the sample timestamp counter
// What this block does
// [R1] Software builds each mode word from one mode, one counter source, one feature constant.
// [R2] Command register is read/write; a write sets mode and runs any encoded command; here a write carrying 1h or 8h runs it and keeps the old mode.
// [R3] Command value zero disables timestamp generation entirely.
// [R4] Explicit-clear mode code is 2h; clear-on-start mode code is 4h.
// [R5] Writing clear command 1h sets the timestamp counter to zero.
// [R6] Explicit-clear mode zeroes the counter only on the clear command; here the await command 8h zeroes it too.
// [R7] After that clear the counter runs on regardless of acquisition start or stop.
// [R8] Captured timestamps are counter values from the common zero of the last clear.
// [R9] Clear-on-start mode zeroes the counter at every card start.
// [R10] After start in clear-on-start mode the counter increments continuously.
// [R11] Source code 100h runs the full-width counter on the sampling clock.
// [R12] Each active reference edge clears the sample counter and bumps the edge counter.
// [R13] Edge counter holds reference edges seen since the last clear.
// [R14] Lower counter holds position within the current reference period in samples.
// [R15] With a one-second reference, upper counts seconds, lower counts position within it.
// [R16] In split mode the clear command zeroes both edge and sample counters.
// [R17] Start time reads hours 23:16, minutes 15:8, seconds 7:0.
// [R18] Start date reads year 31:16, month 15:8, day 7:0.
// [R19] Timeout register holds the longest wait for a reference edge, in milliseconds.
// [R20] Software keeps the sample rate fixed between acquisitions it compares.
// [R21] Source 200h splits on rising reference edges, 400h on falling; lower runs on samples.
// [R22] Command 8h clears counters then awaits a reference edge up to timeout; capture on edge.
// [R23] Counters wrap silently to zero at their maximum and keep counting.
// [R24] While disabled, counters hold and no timestamps are captured on triggers; here the clear and await commands still zero the counter.
package stc_pkg;
    localparam logic [15:0] STC_ADDR_COMMAND = 16'hB798;
    localparam logic [15:0] STC_ADDR_START_TIME = 16'hB7B6;
    localparam logic [15:0] STC_ADDR_START_DATE = 16'hB7B7;
    localparam logic [15:0] STC_ADDR_TIMEOUT = 16'hB7C5;
    localparam logic [31:0] STC_COMMAND_RESET = 32'h0000_0000;
    localparam logic [31:0] STC_TIMEOUT_RESET = 32'h0000_0000;
    localparam logic [31:0] STC_STAMP_OFF_CODE = 32'h0000_0000;
    localparam int STC_BIT_CLEAR_CMD = 0;
    localparam int STC_BIT_EXPLICIT_MODE = 1;
    localparam int STC_BIT_START_MODE = 2;
    localparam int STC_BIT_AWAIT_CMD = 3;
    localparam int STC_BIT_FULL_COUNT = 8;
    localparam int STC_BIT_SPLIT_RISE = 9;
    localparam int STC_BIT_SPLIT_FALL = 10;
    localparam int STC_BIT_NO_EXTRA_FEATURE = 16;
    localparam int STC_STAMP_W = 64;
    localparam int STC_HALF_W = 32;
    localparam int STC_CLOCK_HZ = 100_000_000;
    localparam int STC_MS_PER_S = 1000;
    localparam logic [16:0] STC_CYCLES_PER_MS = 17'(STC_CLOCK_HZ / STC_MS_PER_S);
    typedef enum logic [1:0] {
        STC_IDLE = 2'b01,
        STC_AWAIT = 2'b10
    } stc_state_t;
endpackage : stc_pkg

/* test/sample_timestamp_counter_tb.sv */
// Self-checking bench for the timestamp counter
`timescale 1ns/1ns
module sample_timestamp_counter_tb;
    import stc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0, trig = 1'b0, ref_en = 1'b0;
    logic rvalid, ref_clk, sv, awt, tmo;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0, htime = 32'hAB0C1E2F, hdate = 32'h07E80217, rdata;
    logic [63:0] stamp, cnt, c0;
    int err_total = 0, tests_run = 0;
    // Sample clock rate is never changed during the run
    initial forever #5 clk = ~clk;
    stc_counter DUT (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .HOST_TIME_IN(htime),
        .HOST_DATE_IN(hdate), .CARD_START_IN(start), .TRIGGER_IN(trig), .REF_CLOCK_IN(ref_clk), .STAMP_OUT(stamp),
        .STAMP_VALID_OUT(sv), .COUNT_OUT(cnt), .AWAITING_EDGE_OUT(awt), .SYNC_TIMEOUT_OUT(tmo));
    stc_ref_src #(.HALF(20)) u_ref (.CLOCK_IN(clk), .EN_IN(ref_en), .REF_OUT(ref_clk));
    task automatic chk(input string s, input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", s, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rvalid", rvalid, 64'h1);
        chk("rdata", rdata, e);
    endtask : rd_chk
    task automatic pulse(input logic is_trig);
        @(posedge clk);
        if (is_trig)
            trig <= 1'b1;
        else
            start <= 1'b1;
        #1 c0 = cnt;
        @(posedge clk);
        trig <= 1'b0;
        start <= 1'b0;
        #1;
    endtask : pulse
    task automatic wait_sig(input logic want);
        for (int i = 0; i < 200; i++)
        begin
            cyc(1);
            if (want ? tmo === 1'b1 : awt === 1'b0)
                return;
        end
        err_total++;
        $display("FAIL wait expected %b seen %b", want, ~want);
        end_sim();
    endtask : wait_sig
    task automatic t_std();
        rd_chk(STC_ADDR_COMMAND, STC_COMMAND_RESET);
        wr_reg(STC_ADDR_TIMEOUT, 32'h1);
        rd_chk(STC_ADDR_TIMEOUT, 32'h1);
        // Follows a non-zero read, so stale read data would show
        rd_chk(16'h1234, 32'h0);
        wr_reg(STC_ADDR_COMMAND, 32'h102);
        rd_chk(STC_ADDR_COMMAND, 32'h102);
        wr_reg(STC_ADDR_COMMAND, 32'h1);
        cyc(2);
        chk("cleared", cnt, 64'h2);
        c0 = cnt;
        pulse(1'b0);
        cyc(8);
        chk("free run", cnt, c0 + 64'h9);
        rd_chk(STC_ADDR_COMMAND, 32'h102);
        rd_chk(STC_ADDR_START_TIME, 32'h000C1E2F);
        rd_chk(STC_ADDR_START_DATE, 32'h07E80217);
        pulse(1'b1);
        chk("stamp valid", sv, 64'h1);
        chk("stamp", stamp, c0);
    endtask : t_std
    task automatic t_start_off();
        wr_reg(STC_ADDR_COMMAND, 32'h104);
        cyc(20);
        pulse(1'b0);
        cyc(1);
        chk("start zero", cnt, 64'h1);
        c0 = cnt;
        cyc(7);
        chk("start run", cnt, c0 + 64'h7);
        wr_reg(STC_ADDR_COMMAND, STC_STAMP_OFF_CODE);
        cyc(2);
        pulse(1'b1);
        chk("stamp off", sv, 64'h0);
        cyc(5);
        chk("held", cnt, c0);
    endtask : t_start_off
    task automatic t_split(input logic [31:0] m);
        wr_reg(STC_ADDR_COMMAND, m);
        wr_reg(STC_ADDR_COMMAND, 32'h1);
        cyc(2);
        chk("split clear", cnt, 64'h2);
        @(posedge clk);
        ref_en <= 1'b1;
        cyc(215);
        chk("edges", cnt[63:32], 64'h5);
        chk("position", 64'(cnt[31:0] < 32'h28), 64'h1);
        @(posedge clk);
        ref_en <= 1'b0;
    endtask : t_split
    task automatic t_await();
        wr_reg(STC_ADDR_COMMAND, 32'h202);
        wr_reg(STC_ADDR_TIMEOUT, 32'h0);
        wr_reg(STC_ADDR_COMMAND, 32'h8);
        wait_sig(1'b1);
        wr_reg(STC_ADDR_TIMEOUT, 32'h1);
        wr_reg(STC_ADDR_COMMAND, 32'h8);
        cyc(2);
        chk("awaiting", awt, 64'h1);
        chk("timeout clear", tmo, 64'h0);
        // Time moves on after the command, so only an edge capture sees it
        @(posedge clk);
        htime <= 32'h00173B05;
        ref_en <= 1'b1;
        wait_sig(1'b0);
        chk("no timeout", tmo, 64'h0);
        @(posedge clk);
        ref_en <= 1'b0;
        rd_chk(STC_ADDR_START_TIME, 32'h00173B05);
    endtask : t_await
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_std();
        t_start_off();
        t_split(32'h202);
        t_split(32'h402);
        t_await();
        end_sim();
    end
endmodule : sample_timestamp_counter_tb

/* test/stc_checker.sv */
// Port-level checks for the timestamp counter
`timescale 1ns/1ns
module stc_checker
    import stc_pkg::*;
(
    // Clock, reset and register port
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_RVALID_OUT,
    // Events and results
    input wire logic CARD_START_IN,
    input wire logic TRIGGER_IN,
    input wire logic [63:0] STAMP_OUT,
    input wire logic STAMP_VALID_OUT,
    input wire logic [63:0] COUNT_OUT,
    input wire logic AWAITING_EDGE_OUT
);
    logic [31:0] mode_q, mode_d;
    logic cmd_wr, split;
    assign cmd_wr = REG_WR_IN && REG_ADDR_IN == STC_ADDR_COMMAND;
    assign split = mode_q[9] || mode_q[10];
    // Command words keep the mode, so mirror only mode words
    always_comb
    begin
        mode_d = mode_q;
        if (cmd_wr && !REG_WDATA_IN[0] && !REG_WDATA_IN[3])
            mode_d = REG_WDATA_IN;
    end
    always_ff @(posedge CLOCK_IN)
        mode_q <= RST_N_IN ? mode_d : 32'h0;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_read_answers: assert property (REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read not answered");
    a_clear_zeroes: assert property (cmd_wr && REG_WDATA_IN[0] && mode_q != 0 |-> ##[1:2] COUNT_OUT == 64'h0)
        else $error("clear did not zero");
    a_off_holds: assert property (mode_q == 0 && !REG_WR_IN && !$past(REG_WR_IN) |=> $stable(COUNT_OUT))
        else $error("count moved while off");
    a_off_no_stamp: assert property (mode_q == 0 && TRIGGER_IN |=> !STAMP_VALID_OUT)
        else $error("stamp while off");
    a_stamp_value: assert property (mode_q != 0 && TRIGGER_IN |=> STAMP_VALID_OUT && STAMP_OUT == $past(COUNT_OUT))
        else $error("stamp wrong");
    a_full_counts: assert property (mode_q != 0 && !split && !REG_WR_IN && !$past(REG_WR_IN) && !CARD_START_IN
        && !$past(CARD_START_IN) && !AWAITING_EDGE_OUT |=> COUNT_OUT == $past(COUNT_OUT) + 64'h1)
        else $error("full count not stepping");
    a_start_clears: assert property (mode_q[2] && CARD_START_IN |-> ##[1:2] COUNT_OUT == 64'h0)
        else $error("start did not zero");
    a_edge_resets: assert property (split && COUNT_OUT[63:32] != $past(COUNT_OUT[63:32]) |-> COUNT_OUT[31:0] == 0)
        else $error("lower kept on edge");
    a_await_raise: assert property (cmd_wr && REG_WDATA_IN[3] && mode_q != 0 |-> ##[1:2] AWAITING_EDGE_OUT)
        else $error("await not raised");
endmodule : stc_checker
bind stc_counter stc_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RVALID_OUT(REG_RVALID_OUT),
    .CARD_START_IN(CARD_START_IN), .TRIGGER_IN(TRIGGER_IN), .STAMP_OUT(STAMP_OUT),
    .STAMP_VALID_OUT(STAMP_VALID_OUT), .COUNT_OUT(COUNT_OUT), .AWAITING_EDGE_OUT(AWAITING_EDGE_OUT));

/* test/stc_ref_src.sv */
// Reference clock source model
`timescale 1ns/1ns
module stc_ref_src #(parameter int HALF = 20)
(
    // Clock and enable
    input wire logic CLOCK_IN,
    input wire logic EN_IN,
    // Reference pin
    output logic REF_OUT
);
    int n = 0;
    // Stands low when off; far faster than a real seconds pulse to keep runs short
    always @(posedge CLOCK_IN)
    begin
        n <= (!EN_IN || n == HALF - 1) ? 0 : n + 1;
        REF_OUT <= (EN_IN && n == HALF - 1) ? ~REF_OUT : (EN_IN & REF_OUT);
    end
endmodule : stc_ref_src
